// [hw/peripheral_clock_select.v]
// Purpose: per-peripheral clock-rate selection and core cycle ticks
// Assumes: peripherals take ticks as enables in the system clock domain
// Notes:   registers reached over AXI4-Lite, byte address = 4 x index
`timescale 1ns/10ps
`include "clock_select_map.vh"

// Contract
// R1 - two-wire select only affects master clock
// R2 - compat serial selects: one or two clocks
// R3 - compat timer selects: prescale+1 or double
// R4 - fast mode: one clock or prescale+1
// R5 - watchdog select scales watchdog timeout
// R6 - counter array rate follows count source
// R7 - UART select affects serial modes 0, 2
// R8 - timer 2 select sets up/down rate
// R9 - timer 0/1 selects affect own timer
// R10 - compat core: 12 or 6 clocks
// R11 - fast core: 2 or 1 clocks
// R12 - double-speed bit resets from fuse
// R13 - SPI select is bit 0, master only
// R14 - second register resets select to zero
// R15 - first register bit layout, zero reset; bit 0 resets from the fuse
// R16 - prescale default 0000 fast, 0101 compat
// R17 - ticks are single-cycle enable pulses
// R18 - changes apply at next tick boundary
module peripheral_clock_select (
	// clock, reset and clock enable
	input  wire                    clk,
	input  wire                    rst_b,
	input  wire                    ce,
	// global mode and configuration fuse
	input  wire                    fast_mode,
	input  wire                    double_speed_fuse,
	// peripheral operating state
	input  wire                    two_wire_master,
	input  wire                    spi_master,
	input  wire [1:0]              uart_mode,
	input  wire [1:0]              counter_array_source,
	// AXI4-Lite write address and data
	input  wire [`ADDR_WIDTH-1:0]  awaddr,
	input  wire                    awvalid,
	output wire                    awready,
	input  wire [31:0]             wdata,
	input  wire [3:0]              wstrb,
	input  wire                    wvalid,
	output wire                    wready,
	// AXI4-Lite write response
	output wire [1:0]              bresp,
	output wire                    bvalid,
	input  wire                    bready,
	// AXI4-Lite read
	input  wire [`ADDR_WIDTH-1:0]  araddr,
	input  wire                    arvalid,
	output wire                    arready,
	output wire [31:0]             rdata,
	output wire [1:0]              rresp,
	output wire                    rvalid,
	input  wire                    rready,
	// peripheral ticks
	output wire                    two_wire_tick,
	output wire                    watchdog_tick,
	output wire                    counter_array_tick,
	output wire                    uart_tick,
	output wire                    timer2_tick,
	output wire                    timer1_tick,
	output wire                    timer0_tick,
	output wire                    spi_tick,
	output wire                    core_cycle_tick
);

	localparam NUM_TICKS = 9;

	// ****************************************************************
	// functions
	// ****************************************************************

	// register index from a byte address
	function [7:0] reg_index;
		input [`ADDR_WIDTH-1:0] addr;
		begin
			reg_index = addr[9:2];
		end
	endfunction

	// true when the address names a mapped register
	function mapped;
		input [`ADDR_WIDTH-1:0] addr;
		reg [7:0] idx;
		begin
			idx = reg_index(addr);
			mapped = (addr[1:0] == 2'b00) &&
				(addr[`ADDR_WIDTH-1:10] == 2'b00) &&
				(idx == `IDX_CONTROL_A || idx == `IDX_CONTROL_B ||
				 idx == `IDX_PRESCALE || idx == `IDX_STATUS);
		end
	endfunction

	// system clocks per peripheral tick
	function [5:0] div_period;
		input       fast;
		input       sel;
		input       scaled;
		input       dbl;
		input [3:0] pre;
		reg   [5:0] pre_plus;
		begin
			pre_plus = {2'b00, pre} + 6'h01;
			if (fast)
				div_period = sel ? pre_plus : 6'h01;           // see R4
			else if (scaled)
				div_period = sel ? {pre_plus[4:0], 1'b0}
					: pre_plus;                                // see R3
			else
				div_period = (sel && dbl) ? 6'h02 : 6'h01;     // see R2
		end
	endfunction

	// ****************************************************************
	// registers
	// ****************************************************************
	reg  [7:1] select_a;
	reg        core_double_speed;
	reg        spi_master_clock_select;
	reg  [3:0] timer_prescale_value;

	wire       wr_en;
	wire [`ADDR_WIDTH-1:0] wr_addr;
	wire [31:0] wr_data;
	wire [3:0] wr_strb;
	wire [`ADDR_WIDTH-1:0] rd_addr;
	reg  [31:0] rd_data;
	wire [7:0] wr_idx = reg_index(wr_addr);
	wire       wr_byte = wr_en & wr_strb[0] & mapped(wr_addr);

	wire two_wire_clock_select      = select_a[`BIT_TWO_WIRE_SEL];
	wire watchdog_clock_select      = select_a[`BIT_WATCHDOG_SEL];
	wire counter_array_clock_select = select_a[`BIT_COUNTER_SEL];
	wire uart_clock_select          = select_a[`BIT_UART_SEL];
	wire timer2_clock_select        = select_a[`BIT_TIMER2_SEL];
	wire timer1_clock_select        = select_a[`BIT_TIMER1_SEL];
	wire timer0_clock_select        = select_a[`BIT_TIMER0_SEL];

	always @(posedge clk) begin
		if (!rst_b) begin
			select_a                <= `RESET_CONTROL_A;   // see R15
			core_double_speed       <= double_speed_fuse;  // see R12
			spi_master_clock_select <= `RESET_CONTROL_B;   // see R14
			timer_prescale_value    <= fast_mode
				? `RESET_PRESCALE_FAST
				: `RESET_PRESCALE_COMPAT;                  // see R16
		end else if (ce && wr_byte) begin
			case (wr_idx)
				`IDX_CONTROL_A: begin
					select_a          <= wr_data[7:1];     // see R15
					core_double_speed <= wr_data[`BIT_CORE_DOUBLE];
				end
				`IDX_CONTROL_B: begin
					spi_master_clock_select <=
						wr_data[`BIT_SPI_SEL];             // see R13
				end
				`IDX_PRESCALE: begin
					timer_prescale_value <=
						wr_data[`PRESCALE_MSB:`PRESCALE_LSB];
				end
				default: begin
				end
			endcase
		end
	end

	// ****************************************************************
	// tick periods
	// ****************************************************************
	reg  [5:0] core_period;
	reg  [5:0] counter_period;
	wire [5:0] two_wire_period;
	wire [5:0] uart_period;
	wire [5:0] spi_period;
	wire       uart_rate_mode = (uart_mode == 2'b00) || (uart_mode == 2'b10);

	// select only matters while the two-wire block drives the clock
	assign two_wire_period = two_wire_master
		? div_period(fast_mode, two_wire_clock_select, 1'b0,
			core_double_speed, timer_prescale_value)
		: 6'h01;                                               // see R1

	// baud rate select only in modes 0 and 2
	assign uart_period = uart_rate_mode
		? div_period(fast_mode, uart_clock_select, 1'b0,
			core_double_speed, timer_prescale_value)
		: 6'h01;                                               // see R7

	assign spi_period = spi_master
		? div_period(fast_mode, spi_master_clock_select, 1'b0,
			core_double_speed, timer_prescale_value)
		: 6'h01;                                               // see R13

	// in compat mode source 01 halves on its select alone, other sources are prescaled
	always @* begin
		if (counter_array_source == `SOURCE_PLAIN)
			counter_period = div_period(fast_mode,
				counter_array_clock_select, 1'b0,
				1'b1, timer_prescale_value);                   // see R6
		else
			counter_period = div_period(fast_mode,
				counter_array_clock_select, 1'b1,
				core_double_speed, timer_prescale_value);      // see R3
	end

	always @* begin
		case ({fast_mode, core_double_speed})
			2'b00:   core_period = `CORE_COMPAT_SLOW;          // see R10
			2'b01:   core_period = `CORE_COMPAT_DOUBLE;        // see R10
			2'b10:   core_period = `CORE_FAST_SLOW;            // see R11
			2'b11:   core_period = `CORE_FAST_DOUBLE;          // see R11
			default: core_period = `CORE_COMPAT_SLOW;
		endcase
	end

	wire [6*NUM_TICKS-1:0] periods = {
		core_period,
		spi_period,
		div_period(fast_mode, timer0_clock_select, 1'b1,
			core_double_speed, timer_prescale_value),          // see R9
		div_period(fast_mode, timer1_clock_select, 1'b1,
			core_double_speed, timer_prescale_value),          // see R9
		div_period(fast_mode, timer2_clock_select, 1'b1,
			core_double_speed, timer_prescale_value),          // see R8
		uart_period,
		counter_period,
		div_period(fast_mode, watchdog_clock_select, 1'b1,
			core_double_speed, timer_prescale_value),          // see R5
		two_wire_period
	};

	// ****************************************************************
	// tick generators
	// ****************************************************************
	wire [NUM_TICKS-1:0] ticks;

	genvar gi;
	generate
		for (gi = 0; gi < NUM_TICKS; gi = gi + 1) begin : gen_tick
			tick_divider u_div (
				.clk    (clk),
				.rst_b  (rst_b),
				.ce     (ce),
				.period (periods[6*gi+5:6*gi]),
				.tick   (ticks[gi])
			); // see R17
		end
	endgenerate

	assign two_wire_tick      = ticks[0];
	assign watchdog_tick      = ticks[1];
	assign counter_array_tick = ticks[2];
	assign uart_tick          = ticks[3];
	assign timer2_tick        = ticks[4];
	assign timer1_tick        = ticks[5];
	assign timer0_tick        = ticks[6];
	assign spi_tick           = ticks[7];
	assign core_cycle_tick    = ticks[8];

	// ****************************************************************
	// read decode
	// ****************************************************************
	always @* begin
		rd_data = 32'h0000_0000;
		case (reg_index(rd_addr))
			`IDX_CONTROL_A:
				rd_data[7:0] = {select_a, core_double_speed};
			`IDX_CONTROL_B:
				rd_data[`BIT_SPI_SEL] = spi_master_clock_select;
			`IDX_PRESCALE:
				rd_data[`PRESCALE_MSB:`PRESCALE_LSB] = timer_prescale_value;
			`IDX_STATUS:
				rd_data[7:0] = {fast_mode, two_wire_master, spi_master,
					core_period[4:0]};
			default:
				rd_data = 32'h0000_0000;
		endcase
	end

	// ****************************************************************
	// bus slave
	// ****************************************************************
	axil_reg_port u_port (
		.clk     (clk),
		.rst_b   (rst_b),
		.ce      (ce),
		.awaddr  (awaddr),
		.awvalid (awvalid),
		.awready (awready),
		.wdata   (wdata),
		.wstrb   (wstrb),
		.wvalid  (wvalid),
		.wready  (wready),
		.bresp   (bresp),
		.bvalid  (bvalid),
		.bready  (bready),
		.araddr  (araddr),
		.arvalid (arvalid),
		.arready (arready),
		.rdata   (rdata),
		.rresp   (rresp),
		.rvalid  (rvalid),
		.rready  (rready),
		.wr_en   (wr_en),
		.wr_addr (wr_addr),
		.wr_data (wr_data),
		.wr_strb (wr_strb),
		.wr_ok   (mapped(wr_addr) && reg_index(wr_addr) != `IDX_STATUS),
		.rd_addr (rd_addr),
		.rd_data (rd_data),
		.rd_ok   (mapped(rd_addr))
	);

endmodule

// [inc/clock_select_map.vh]
// Purpose: register map, field positions, reset values and cycle counts
//          of the peripheral clock select block
// Assumes: included by bare name from the hw/ design files
// Notes:   byte address of a register is four times its index
`ifndef CLOCK_SELECT_MAP_VH
`define CLOCK_SELECT_MAP_VH

// ****************************************************************
// register indices and address width
// ****************************************************************
`define IDX_CONTROL_A        8'h8F
`define IDX_CONTROL_B        8'hAF
`define IDX_PRESCALE         8'hAE
`define IDX_STATUS           8'hF0
`define ADDR_WIDTH           12

// ****************************************************************
// field positions of peripheral_clock_control_a
// ****************************************************************
`define BIT_CORE_DOUBLE      0
`define BIT_TIMER0_SEL       1
`define BIT_TIMER1_SEL       2
`define BIT_TIMER2_SEL       3
`define BIT_UART_SEL         4
`define BIT_COUNTER_SEL      5
`define BIT_WATCHDOG_SEL     6
`define BIT_TWO_WIRE_SEL     7

// ****************************************************************
// field positions of peripheral_clock_control_b and prescale register
// ****************************************************************
`define BIT_SPI_SEL          0
`define PRESCALE_MSB         7
`define PRESCALE_LSB         4

// ****************************************************************
// reset values
// ****************************************************************
`define RESET_CONTROL_A      7'h00
`define RESET_CONTROL_B      1'b0
`define RESET_PRESCALE_FAST  4'h0
`define RESET_PRESCALE_COMPAT 4'h5

// ****************************************************************
// system clocks per core cycle
// ****************************************************************
`define CORE_COMPAT_SLOW     6'h0C
`define CORE_COMPAT_DOUBLE   6'h06
`define CORE_FAST_SLOW       6'h02
`define CORE_FAST_DOUBLE     6'h01

// ****************************************************************
// counter array count sources and bus responses
// ****************************************************************
`define SOURCE_PRESCALED     2'b00
`define SOURCE_PLAIN         2'b01
`define RESP_OKAY            2'b00
`define RESP_SLVERR          2'b10

`endif

// [hw/tick_divider.v]
// Purpose: divides the system clock into single-cycle tick pulses
// Assumes: period is at least one
// Notes:   a new period is taken only at a tick boundary
`timescale 1ns/10ps

module tick_divider (
	// clock and reset
	input  wire       clk,
	input  wire       rst_b,
	input  wire       ce,
	// requested period in system clocks
	input  wire [5:0] period,
	// tick out
	output reg        tick
);

	reg [5:0] count;
	reg [5:0] cur_period;

	// ****************************************************************
	// counter, reloads the period only when a tick is produced
	// ****************************************************************
	always @(posedge clk) begin
		if (!rst_b) begin
			count      <= 6'h00;
			cur_period <= 6'h01;
			tick       <= 1'b0;
		end else if (ce) begin
			if (count == cur_period - 6'h01) begin
				count      <= 6'h00;
				cur_period <= period; // see R18
				tick       <= 1'b1;   // see R17
			end else begin
				count <= count + 6'h01;
				tick  <= 1'b0;
			end
		end
	end

endmodule

// [hw/axil_reg_port.v]
// Purpose: AXI4-Lite slave front end for a small register file
// Assumes: one write and one read at most under way
// Notes:   write and read answers come from flip-flops
`timescale 1ns/10ps
`include "clock_select_map.vh"

module axil_reg_port (
	// clock and reset
	input  wire                    clk,
	input  wire                    rst_b,
	input  wire                    ce,
	// write address and data
	input  wire [`ADDR_WIDTH-1:0]  awaddr,
	input  wire                    awvalid,
	output reg                     awready,
	input  wire [31:0]             wdata,
	input  wire [3:0]              wstrb,
	input  wire                    wvalid,
	output reg                     wready,
	// write response
	output reg  [1:0]              bresp,
	output reg                     bvalid,
	input  wire                    bready,
	// read address and data
	input  wire [`ADDR_WIDTH-1:0]  araddr,
	input  wire                    arvalid,
	output reg                     arready,
	output reg  [31:0]             rdata,
	output reg  [1:0]              rresp,
	output reg                     rvalid,
	input  wire                    rready,
	// register file side
	output wire                    wr_en,
	output reg  [`ADDR_WIDTH-1:0]  wr_addr,
	output reg  [31:0]             wr_data,
	output reg  [3:0]              wr_strb,
	input  wire                    wr_ok,
	output wire [`ADDR_WIDTH-1:0]  rd_addr,
	input  wire [31:0]             rd_data,
	input  wire                    rd_ok
);

	reg  aw_held;
	reg  w_held;
	wire aw_take = awvalid & awready;
	wire w_take  = wvalid & wready;
	wire ar_take = arvalid & arready;
	wire next_aw_held = aw_held ? ~wr_en : aw_take;
	wire next_w_held  = w_held ? ~wr_en : w_take;
	wire next_rvalid  = rvalid ? ~rready : ar_take;

	assign wr_en   = aw_held & w_held & ~bvalid & ce;
	assign rd_addr = araddr;

	// ****************************************************************
	// write channels, address and data taken in either order
	// ****************************************************************
	always @(posedge clk) begin
		if (!rst_b) begin
			aw_held <= 1'b0;
			w_held  <= 1'b0;
			awready <= 1'b0;
			wready  <= 1'b0;
			bvalid  <= 1'b0;
			bresp   <= `RESP_OKAY;
			wr_addr <= {`ADDR_WIDTH{1'b0}};
			wr_data <= 32'h0000_0000;
			wr_strb <= 4'h0;
		end else if (ce) begin
			if (aw_take)
				wr_addr <= awaddr;
			if (w_take) begin
				wr_data <= wdata;
				wr_strb <= wstrb;
			end
			aw_held <= next_aw_held;
			w_held  <= next_w_held;
			awready <= ~next_aw_held;
			wready  <= ~next_w_held;
			if (wr_en) begin
				bvalid <= 1'b1;
				bresp  <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
			end else if (bready)
				bvalid <= 1'b0;
		end
	end

	// ****************************************************************
	// read channel, data registered on address acceptance
	// ****************************************************************
	always @(posedge clk) begin
		if (!rst_b) begin
			arready <= 1'b0;
			rvalid  <= 1'b0;
			rdata   <= 32'h0000_0000;
			rresp   <= `RESP_OKAY;
		end else if (ce) begin
			rvalid  <= next_rvalid;
			arready <= ~next_rvalid;
			if (ar_take) begin
				rdata <= rd_data;
				rresp <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
			end
		end
	end

endmodule

// [verification/tick_consumer.sv]
// Purpose: peripheral side model, measures the spacing of every tick
// Assumes: ticks are enables in the system clock domain
// Notes:   gap holds system clocks between the last two pulses
`timescale 1ns/10ps

module tick_consumer (
	// clock and reset
	input  wire        clk,
	input  wire        rst_b,
	// ticks in
	input  wire  [8:0] ticks,
	// measured spacing
	output logic [7:0] gap [9]
);
	logic [7:0] cnt [9];

	// ****************************************************
	// spacing counters
	// ****************************************************
	always @(posedge clk) begin
		for (int i = 0; i < 9; i++) begin
			if (!rst_b) begin
				cnt[i] <= 8'h00;
				gap[i] <= 8'h00;
			end else if (ticks[i]) begin
				gap[i] <= cnt[i] + 8'h01;
				cnt[i] <= 8'h00;
			end else if (cnt[i] != 8'hFF) begin
				cnt[i] <= cnt[i] + 8'h01;
			end
		end
	end
endmodule

// [verification/clock_select_monitor.sv]
// Purpose: concurrent checks on the clock select block ports
// Assumes: bound to the top module of the block
// Notes:   period rules are checked where a single cycle tells
`timescale 1ns/10ps
`include "clock_select_map.vh"

module clock_select_monitor (
	// clock and control
	input wire                   clk,
	input wire                   rst_b,
	input wire                   ce,
	input wire                   fast_mode,
	input wire                   two_wire_master,
	input wire                   spi_master,
	input wire [1:0]             uart_mode,
	// register bus
	input wire                   awvalid,
	input wire                   awready,
	input wire                   wvalid,
	input wire                   wready,
	input wire [1:0]             bresp,
	input wire                   bvalid,
	input wire                   bready,
	input wire [`ADDR_WIDTH-1:0] araddr,
	input wire                   arvalid,
	input wire                   arready,
	input wire [1:0]             rresp,
	input wire                   rvalid,
	// ticks
	input wire                   two_wire_tick,
	input wire                   uart_tick,
	input wire                   spi_tick,
	input wire                   core_cycle_tick
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);

	// ****************************************************
	// assertions
	// ****************************************************
	a_two_wire_slave: assert property (ce && $past(ce)
		&& $past(two_wire_tick) && !$past(two_wire_master, 2)
		|-> two_wire_tick)
		else $error("two-wire tick gap not one outside master role");
	a_spi_slave_rate: assert property (ce && $past(ce)
		&& $past(spi_tick) && !$past(spi_master, 2) |-> spi_tick)
		else $error("spi tick gap not one outside master role");
	a_uart_mode_rate: assert property (ce && $past(ce)
		&& $past(uart_tick) && $past(uart_mode[0], 2) |-> uart_tick)
		else $error("uart tick gap not one in modes 1 and 3");
	a_core_compat_pulse: assert property (ce && !fast_mode
		&& $past(rst_b) && core_cycle_tick |=> !core_cycle_tick)
		else $error("core tick repeated in compatibility mode");
	a_core_fast_rate: assert property (ce && fast_mode
		&& core_cycle_tick |=> ##[0:1] core_cycle_tick)
		else $error("core tick gap above two in fast mode");
	a_write_answer: assert property (ce && awvalid && awready
		&& wvalid && wready |=> ##1 bvalid)
		else $error("write response late");
	a_aw_refused: assert property (ce && awvalid && awready |=> !awready)
		else $error("write address taken twice");
	a_bresp_hold: assert property (bvalid && !bready
		|=> bvalid && $stable(bresp))
		else $error("write response dropped before taken");
	a_read_answer: assert property (ce && arvalid && arready |=> rvalid)
		else $error("read data late");
	a_read_unmapped: assert property (ce && arvalid && arready
		&& araddr == 12'h000 |=> rresp == `RESP_SLVERR)
		else $error("unmapped read not refused");
endmodule

// [verification/peripheral_clock_select_tb_top.sv]
// Purpose: self-checking bench for the peripheral clock select block
// Assumes: clock enable held high, registers in the low data byte
// Notes:   tick spacing comes from the tick consumer model
`timescale 1ns/10ps
`include "clock_select_map.vh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
	n_mismatch++; $display("wrong value %s exp %0h got %0h", nm, e, g); \
	end end

module peripheral_clock_select_tb_top;
	logic        clk = 1'b0, rst_b = 1'b0, ce = 1'b1;
	logic        fast_mode = 1'b0, double_speed_fuse = 1'b0;
	logic        two_wire_master = 1'b0, spi_master = 1'b0;
	logic [1:0]  uart_mode = 2'b00, counter_array_source = 2'b00;
	logic [11:0] awaddr = 12'h000, araddr = 12'h000;
	logic [31:0] wdata = 32'h00000000;
	logic [3:0]  wstrb = 4'h0;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic        arvalid = 1'b0, rready = 1'b0;
	wire         awready, wready, bvalid, arready, rvalid;
	wire  [1:0]  bresp, rresp;
	wire  [31:0] rdata;
	wire         two_wire_tick, watchdog_tick, counter_array_tick;
	wire         uart_tick, timer2_tick, timer1_tick, timer0_tick;
	wire         spi_tick, core_cycle_tick;
	logic [7:0]  gap [9];
	int          n_mismatch = 0, n_checks = 0, cyc = 0;
	wire  [8:0]  ticks = {core_cycle_tick, spi_tick, timer0_tick,
		timer1_tick, timer2_tick, uart_tick, counter_array_tick,
		watchdog_tick, two_wire_tick};
	localparam logic [11:0] ADR_A = {2'b00, `IDX_CONTROL_A, 2'b00};
	localparam logic [11:0] ADR_B = {2'b00, `IDX_CONTROL_B, 2'b00};
	localparam logic [11:0] ADR_P = {2'b00, `IDX_PRESCALE, 2'b00};

	peripheral_clock_select dut (.clk, .rst_b, .ce, .fast_mode,
		.double_speed_fuse, .two_wire_master, .spi_master, .uart_mode,
		.counter_array_source, .awaddr, .awvalid, .awready, .wdata, .wstrb,
		.wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
		.arready, .rdata, .rresp, .rvalid, .rready, .two_wire_tick,
		.watchdog_tick, .counter_array_tick, .uart_tick, .timer2_tick,
		.timer1_tick, .timer0_tick, .spi_tick, .core_cycle_tick);
	tick_consumer far (.clk, .rst_b, .ticks, .gap);

	// ****************************************************
	// clock, timeout and verdict
	// ****************************************************
	initial begin
		forever #2.5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			print_verdict();
		end
	end
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// ****************************************************
	// drivers
	// ****************************************************
	task automatic do_reset(input logic f, input logic fu);
		@(posedge clk);
		fast_mode <= f;
		double_speed_fuse <= fu;
		rst_b <= 1'b0;
		repeat (12) @(posedge clk);
		rst_b <= 1'b1;
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		int t;
		t = 0;
		@(posedge clk);
		awaddr <= a;
		wdata <= {24'h000000, d};
		wstrb <= 4'hF;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			t++;
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1 && t < 100);
		if (bvalid !== 1'b1) n_mismatch++;
		bready <= 1'b0;
		`CHK("bresp", `RESP_OKAY, bresp)
	endtask
	task automatic rc(input string nm, input logic [11:0] a,
		input logic [31:0] e, input logic [1:0] er);
		int t;
		t = 0;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			t++;
			if (arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1 && t < 100);
		if (rvalid !== 1'b1) n_mismatch++;
		rready <= 1'b0;
		`CHK("rresp", er, rresp)
		if (er === `RESP_OKAY) `CHK(nm, e, rdata)
	endtask
	// waits for three pulses, then compares the last spacing
	task automatic per(input int i, input logic [7:0] e);
		int t;
		repeat (3) begin
			t = 0;
			do begin
				@(negedge clk);
				t++;
			end while (ticks[i] !== 1'b1 && t < 200);
			if (ticks[i] !== 1'b1) n_mismatch++;
		end
		@(posedge clk);
		#1;
		`CHK("tick gap", e, gap[i])
	endtask

	// ****************************************************
	// scenarios
	// ****************************************************
	task automatic t_reset();
		do_reset(1'b0, 1'b1);
		rc("control_a", ADR_A, 32'h00000001, `RESP_OKAY);
		rc("control_b", ADR_B, 32'h00000000, `RESP_OKAY);
		rc("prescale", ADR_P, 32'h00000050, `RESP_OKAY);
		rc("unmapped", 12'h000, 32'h00000000, `RESP_SLVERR);
		do_reset(1'b0, 1'b0);
		rc("control_a", ADR_A, 32'h00000000, `RESP_OKAY);
		$display("test reset values done");
	endtask
	task automatic t_compat();
		per(6, 8'h06);
		per(8, 8'h0C);
		wr(ADR_A, 8'h4B);
		per(6, 8'h0C);
		per(5, 8'h06);
		per(4, 8'h0C);
		per(1, 8'h0C);
		per(8, 8'h06);
		per(3, 8'h01);
		wr(ADR_A, 8'hB1);
		two_wire_master <= 1'b1;
		per(0, 8'h02);
		per(3, 8'h02);
		per(2, 8'h0C);
		uart_mode <= 2'b01;
		per(3, 8'h01);
		uart_mode <= 2'b10;
		per(3, 8'h02);
		counter_array_source <= 2'b01;
		per(2, 8'h02);
		two_wire_master <= 1'b0;
		per(0, 8'h01);
		wr(ADR_B, 8'h01);
		rc("control_b", ADR_B, 32'h00000001, `RESP_OKAY);
		spi_master <= 1'b1;
		per(7, 8'h02);
		spi_master <= 1'b0;
		per(7, 8'h01);
		wr(ADR_A, 8'h30);
		per(3, 8'h01);
		per(2, 8'h02);
		per(8, 8'h0C);
		$display("test compatibility rates done");
	endtask
	task automatic t_fast();
		do_reset(1'b1, 1'b1);
		rc("prescale", ADR_P, 32'h00000000, `RESP_OKAY);
		per(8, 8'h01);
		per(6, 8'h01);
		wr(ADR_P, 8'h30);
		wr(ADR_A, 8'h02);
		per(8, 8'h02);
		per(6, 8'h04);
		per(5, 8'h01);
		wr(ADR_B, 8'h01);
		spi_master <= 1'b1;
		per(7, 8'h04);
		$display("test fast rates done");
	endtask

	initial begin
		t_reset();
		t_compat();
		t_fast();
		print_verdict();
	end
endmodule

bind peripheral_clock_select clock_select_monitor mon (.clk, .rst_b, .ce,
	.fast_mode, .two_wire_master, .spi_master, .uart_mode, .awvalid,
	.awready, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
	.arvalid, .arready, .rresp, .rvalid, .two_wire_tick, .uart_tick,
	.spi_tick, .core_cycle_tick);
